// >>> dv/lpt_panel_model.sv
// Panel-side model: pixel source plus line and frame timing monitor.
// Assumes one pixel per aclk and registered sync outputs from the timing block.
`timescale 1ns/1ps
module lpt_panel_model
  import lpt_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Panel link
  input  wire logic [7:0]  panel_pixel_data,
  input  wire logic        line_sync_pulse,
  input  wire logic        frame_sync_pulse,
  input  wire logic        pixel_ready,
  output      logic [7:0]  pixel_in,
  // Measurements
  output      logic [15:0] m_line_per,
  output      logic [15:0] m_ready,
  output      logic [15:0] m_data,
  output      logic [15:0] m_sync_w,
  output      logic [15:0] m_gap,
  output      logic [15:0] m_flines,
  output      logic [15:0] m_dlines,
  output      logic [15:0] m_fgap,
  output      logic [15:0] m_frames
);
  logic [7:0]  pix_ff;
  logic        ls_q;
  logic        fs_q;
  logic        had_data;
  logic [15:0] hc, rdy_c, dat_c, w_c, gap_c, ln_c, blk_c, dl_c;

  // Source changes every second cycle and is never zero
  assign pixel_in = pix_ff | 8'h01;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {pix_ff, ls_q, fs_q, had_data, hc, rdy_c, dat_c, w_c, gap_c} <= '0;
      {ln_c, blk_c, dl_c, m_line_per, m_ready, m_data, m_sync_w, m_gap} <= '0;
      {m_flines, m_dlines, m_fgap, m_frames} <= '0;
    end
    else
    begin
      pix_ff <= pix_ff + 8'h01;
      ls_q   <= line_sync_pulse;
      fs_q   <= frame_sync_pulse;
      hc     <= hc + 16'h0001;
      rdy_c  <= rdy_c + {15'h0, pixel_ready};
      dat_c  <= dat_c + {15'h0, |panel_pixel_data};
      gap_c  <= pixel_ready ? 16'h0000 : gap_c + 16'h0001;
      w_c    <= w_c + {15'h0, line_sync_pulse};
      if (pixel_ready)
        had_data <= 1'b1;
      if (!line_sync_pulse && ls_q)
      begin
        m_sync_w <= w_c;
        w_c      <= '0;
      end
      // Line boundary taken at each sync leading edge
      if (line_sync_pulse && !ls_q)
      begin
        m_line_per <= hc;
        hc         <= 16'h0001;
        if (had_data)
          m_gap <= gap_c;
        if (rdy_c != '0)
          m_ready <= rdy_c;
        if (dat_c != '0)
          m_data <= dat_c;
        rdy_c    <= '0;
        dat_c    <= {15'h0, |panel_pixel_data};
        blk_c    <= had_data ? 16'h0000 : blk_c + 16'h0001;
        dl_c     <= dl_c + {15'h0, had_data};
        had_data <= 1'b0;
        ln_c     <= ln_c + 16'h0001;
      end
      if (frame_sync_pulse && !fs_q)
      begin
        m_flines <= ln_c;
        m_dlines <= dl_c;
        m_fgap   <= blk_c;
        ln_c     <= '0;
        dl_c     <= '0;
        m_frames <= m_frames + 16'h0001;
      end
    end
  end
endmodule

// >>> dv/lpt_timing_bench.sv
// Bench for the panel timing block: AXI4-Lite register tasks and timing checks.
// Assumes the panel model measures every line and frame on the panel link.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("FAIL %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module lpt_timing_bench
  import lpt_pkg::*;
;
  logic        aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pixel_in, panel_pixel_data;
  logic        pixel_ready, line_sync_pulse, frame_sync_pulse, active_matrix_mode;
  logic [15:0] m_line_per, m_ready, m_data, m_sync_w, m_gap;
  logic [15:0] m_flines, m_dlines, m_fgap, m_frames;
  int          n_mismatch = 0;
  int          checked = 0;

  lpt_timing dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pixel_in(pixel_in),
    .pixel_ready(pixel_ready), .panel_pixel_data(panel_pixel_data),
    .line_sync_pulse(line_sync_pulse), .frame_sync_pulse(frame_sync_pulse),
    .active_matrix_mode(active_matrix_mode));

  lpt_panel_model panel_u (.aclk(aclk), .aresetn(aresetn),
    .panel_pixel_data(panel_pixel_data), .line_sync_pulse(line_sync_pulse),
    .frame_sync_pulse(frame_sync_pulse), .pixel_ready(pixel_ready), .pixel_in(pixel_in),
    .m_line_per(m_line_per), .m_ready(m_ready), .m_data(m_data), .m_sync_w(m_sync_w),
    .m_gap(m_gap), .m_flines(m_flines), .m_dlines(m_dlines), .m_fgap(m_fgap),
    .m_frames(m_frames));

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic limit(input int n, input int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      $display("FAIL wait bound used up");
      close_out();
    end
  endtask

  function automatic logic [31:0] ba(input logic [5:0] idx);
    return {24'h0, idx, 2'b00};
  endfunction

  task automatic axw(input logic [31:0] a, input logic [7:0] d, output logic [1:0] rsp);
    int   n;
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      if (ad && dd && s_axi_bvalid === 1'b1)
        break;
      if (!ad && s_axi_awready === 1'b1)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1)
      begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    limit(n, 50);
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rsp);
    int   n;
    logic ad;
    ad = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      if (ad && s_axi_rvalid === 1'b1)
        break;
      if (!ad && s_axi_arready === 1'b1)
      begin
        ad = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    limit(n, 50);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [1:0] rsp;
    axw(ba(idx), d, rsp);
    `CHK("write response", RESP_OKAY, rsp)
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  rsp;
    axr(a, d, rsp);
    `CHK("read data", exp, d)
    `CHK("read response", er, rsp)
  endtask

  // Program a geometry, let three frames pass, compare measured timing
  task automatic run_cfg(input logic am, input logic [6:0] hs, input logic [9:0] vs,
                         input logic [4:0] lp, input logic [4:0] hb,
                         input logic [5:0] fp, input logic [5:0] vb);
    logic [15:0] w, f0;
    int          n;
    wr(IDX_HSIZE, {1'b0, hs});
    wr(IDX_VSIZE_LO, vs[7:0]);
    wr(IDX_VSIZE_HI, {6'h0, vs[9:8]});
    wr(IDX_HBLANK, {3'h0, hb});
    wr(IDX_LINE_POS, {3'h0, lp});
    wr(IDX_VBLANK, {2'h0, vb});
    wr(IDX_FRAME_POS, {2'h0, fp});
    wr(IDX_PANEL_CFG, {am, 7'h00});
    f0 = m_frames;
    for (n = 0; n < 30000 && m_frames !== f0 + 16'h0003; n++)
      @(posedge aclk);
    limit(n, 30000);
    w = ({9'h0, hs} + 16'h0001) * 16'h0008;
    `CHK("active width", w, m_ready)
    `CHK("data cycles", w, m_data)
    `CHK("line period", w + ({11'h0, hb} + 16'h0004) * 16'h0008, m_line_per)
    `CHK("sync width", {5'h00, LSYNC_PIX}, m_sync_w)
    `CHK("sync delay", am ? ({11'h0, lp} + 16'h0002) * 16'h0008 + 16'h0001 : 16'h0001, m_gap)
    `CHK("data lines", {6'h0, vs} + 16'h0001, m_dlines)
    `CHK("frame lines", {6'h0, vs} + 16'h0001 + {10'h0, vb}, m_flines)
    `CHK("frame delay", am ? {10'h0, fp} - 16'h0001 : 16'h0000, m_fgap)
    `CHK("panel type", am, active_matrix_mode)
    rd(ba(IDX_VBLANK), {24'h0, 2'b10, vb}, RESP_OKAY);
    $display("test timing mode %0d done", am);
  endtask

  initial
  begin
    logic [5:0]  ri [8];
    logic [7:0]  rv [8];
    logic [1:0]  rsp;
    ri = '{IDX_PANEL_CFG, IDX_HSIZE, IDX_VSIZE_LO, IDX_VSIZE_HI, IDX_LINE_POS, IDX_HBLANK,
           IDX_FRAME_POS, IDX_VBLANK};
    rv = '{{RST_AMODE, 7'h00}, {1'b0, RST_HSIZE}, RST_VSIZE[7:0], {6'h0, RST_VSIZE[9:8]},
           {3'h0, RST_LINE_POS}, {3'h0, RST_HBLANK}, {2'h0, RST_FRAME_POS}, {2'h0, RST_VBLANK}};
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(ba(ri[i]), {24'h0, rv[i]}, RESP_OKAY);
    $display("test reset values done");
    rd(ba(6'h0b), 32'h0, RESP_SLVERR);
    rd(32'h0000_0011, 32'h0, RESP_SLVERR);
    axw(ba(6'h0b), 8'h5a, rsp);
    `CHK("unmapped write", RESP_SLVERR, rsp)
    $display("test unmapped done");
    wr(IDX_VSIZE_LO, 8'hff);
    wr(IDX_VSIZE_HI, 8'h03);
    rd(ba(IDX_VSIZE_LO), 32'h0000_00ff, RESP_OKAY);
    rd(ba(IDX_VSIZE_HI), 32'h0000_0003, RESP_OKAY);
    $display("test vertical size limit done");
    run_cfg(1'b0, 7'h03, 10'h003, 5'h02, 5'h03, 6'h03, 6'h04);
    run_cfg(1'b1, 7'h03, 10'h003, 5'h02, 5'h03, 6'h03, 6'h04);
    run_cfg(1'b1, 7'h05, 10'h002, 5'h00, 5'h00, 6'h01, 6'h01);
    close_out();
  end
endmodule

// >>> hw/lpt_axil_slave.sv
// AXI4-Lite slave front end for the panel timing registers.
// Assumes the register file decodes the word index and answers in the same cycle.
`timescale 1ns/1ps
module lpt_axil_slave
  import lpt_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write channels
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read channels
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register file side
  output      lpt_wr_s     wr,
  input  wire logic        wr_ok,
  output      logic [5:0]  rd_idx,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_ok
);

  logic        aw_held_ff, nxt_aw_held;
  logic [31:0] awaddr_ff,  nxt_awaddr;
  logic        w_held_ff,  nxt_w_held;
  logic [7:0]  wdata_ff,   nxt_wdata;
  logic        wstrb0_ff,  nxt_wstrb0;
  logic        bvalid_ff,  nxt_bvalid;
  logic [1:0]  bresp_ff,   nxt_bresp;
  logic        rvalid_ff,  nxt_rvalid;
  logic [31:0] rdata_ff,   nxt_rdata;
  logic [1:0]  rresp_ff,   nxt_rresp;
  logic        do_wr;
  logic        wr_hit;
  logic        rd_hit;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Address and data may arrive in either order
  assign do_wr   = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_hit  = wr_ok && (awaddr_ff[31:8] == 24'h000000) && (awaddr_ff[1:0] == 2'b00);
  assign wr.en   = do_wr && wr_hit && wstrb0_ff;
  assign wr.idx  = awaddr_ff[7:2];
  assign wr.data = wdata_ff;
  assign rd_idx  = s_axi_araddr[7:2];
  assign rd_hit  = rd_ok && (s_axi_araddr[31:8] == 24'h000000) && (s_axi_araddr[1:0] == 2'b00);

  always_comb
  begin
    nxt_aw_held = aw_held_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_w_held  = w_held_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb0  = wstrb0_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw_held = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axi_wdata[7:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (do_wr)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
  end

  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_hit ? {24'h000000, rd_data} : 32'h00000000;
      nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 32'h00000000;
      w_held_ff  <= 1'b0;
      wdata_ff   <= 8'h00;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= RESP_OKAY;
    end
    else
    begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff  <= nxt_awaddr;
      w_held_ff  <= nxt_w_held;
      wdata_ff   <= nxt_wdata;
      wstrb0_ff  <= nxt_wstrb0;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

endmodule

// >>> hw/lpt_pkg.sv
// Constants and carriers for the panel timing register block.
// Assumes a single pixel-rate clock and an AXI4-Lite master outside.
package lpt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PANEL_CFG   = 6'h01;
  localparam logic [5:0] IDX_HSIZE       = 6'h04;
  localparam logic [5:0] IDX_VSIZE_LO    = 6'h05;
  localparam logic [5:0] IDX_VSIZE_HI    = 6'h06;
  localparam logic [5:0] IDX_LINE_POS    = 6'h07;
  localparam logic [5:0] IDX_HBLANK      = 6'h08;
  localparam logic [5:0] IDX_FRAME_POS   = 6'h09;
  localparam logic [5:0] IDX_VBLANK      = 6'h0a;

  // Field positions
  localparam int         AMODE_BIT       = 7;
  localparam int         VBLANK_STAT_BIT = 7;

  // Reset values
  localparam logic       RST_AMODE       = 1'b0;
  localparam logic [6:0] RST_HSIZE       = 7'h27;
  localparam logic [9:0] RST_VSIZE       = 10'h0ef;
  localparam logic [4:0] RST_LINE_POS    = 5'h00;
  localparam logic [4:0] RST_HBLANK      = 5'h00;
  localparam logic [5:0] RST_FRAME_POS   = 6'h01;
  localparam logic [5:0] RST_VBLANK      = 6'h01;

  // Timing arithmetic, in 8-pixel groups or in pixels
  localparam logic [5:0] LINE_POS_ADD    = 6'h02;
  localparam logic [5:0] HBLANK_ADD      = 6'h04;
  localparam logic [10:0] LSYNC_PIX      = 11'h008;

  // Bus answers
  localparam logic [1:0] RESP_OKAY       = 2'b00;
  localparam logic [1:0] RESP_SLVERR     = 2'b10;

  typedef struct packed {
    logic       amode;
    logic [6:0] hsize;
    logic [9:0] vsize;
    logic [4:0] line_pos;
    logic [4:0] hblank;
    logic [5:0] frame_pos;
    logic [5:0] vblank;
  } lpt_cfg_s;

  typedef struct packed {
    logic       en;
    logic [5:0] idx;
    logic [7:0] data;
  } lpt_wr_s;

endpackage

// >>> hw/lpt_timing.sv
// Panel geometry registers and line/frame timing generator.
// Assumes aclk is the pixel clock, one pixel per cycle, and an AXI4-Lite host.
// Summary of operation
// - Active width is (horizontal size + 1) times 8 pixels.
// - Active height is 10-bit vertical size plus one, split low/high.
// - Vertical size accepts up to 3FFh, i.e. 1024 lines.
// - Active mode: line sync starts (line position + 2) * 8 pixels after data.
// - Line and frame positions matter only in active-matrix mode.
// - Horizontal blank after each line lasts (value + 4) * 8 pixels.
// - Active mode: frame sync starts frame-position lines after last data line.
// - Panel type bit: zero passive, one active-matrix.
// - Vertical blank after each frame lasts the 6-bit value in lines.
`timescale 1ns/1ps
module lpt_timing
  import lpt_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pixel source
  input  wire logic [7:0]  pixel_in,
  output      logic        pixel_ready,
  // Panel
  output      logic [7:0]  panel_pixel_data,
  output      logic        line_sync_pulse,
  output      logic        frame_sync_pulse,
  output      logic        active_matrix_mode
);

  lpt_cfg_s    cfg_ff, nxt_cfg;
  lpt_wr_s     wr;
  logic        wr_ok;
  logic [5:0]  rd_idx;
  logic [7:0]  rd_data;
  logic        rd_ok;

  logic [10:0] hcnt_ff, nxt_hcnt;
  logic [10:0] vcnt_ff, nxt_vcnt;
  logic [7:0]  pix_ff,  nxt_pix;
  logic        lsync_ff, nxt_lsync;
  logic        fsync_ff, nxt_fsync;

  logic [10:0] w_pix;
  logic [10:0] hblank_pix;
  logic [10:0] line_total;
  logic [10:0] lpos_pix;
  logic [10:0] lsync_start;
  logic [10:0] v_lines;
  logic [10:0] frame_total;
  logic [10:0] fsync_line;
  logic        in_hact;
  logic        in_vact;
  logic        in_act;
  logic        line_end;
  logic        frame_end;

  lpt_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .wr_ok         (wr_ok),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // Index decode, apart from the write path
  always_comb
  begin
    unique case (wr.idx)
      IDX_PANEL_CFG, IDX_HSIZE, IDX_VSIZE_LO, IDX_VSIZE_HI,
      IDX_LINE_POS, IDX_HBLANK, IDX_FRAME_POS, IDX_VBLANK: wr_ok = 1'b1;
      default:                                               wr_ok = 1'b0;
    endcase
  end

  // Register writes; only the documented field bits are stored
  always_comb
  begin
    nxt_cfg = cfg_ff;
    unique case (wr.idx)
      IDX_PANEL_CFG: if (wr.en) nxt_cfg.amode = wr.data[AMODE_BIT];
      IDX_HSIZE:     if (wr.en) nxt_cfg.hsize = wr.data[6:0];
      IDX_VSIZE_LO:  if (wr.en) nxt_cfg.vsize[7:0] = wr.data;
      IDX_VSIZE_HI:  if (wr.en) nxt_cfg.vsize[9:8] = wr.data[1:0];
      IDX_LINE_POS:  if (wr.en) nxt_cfg.line_pos = wr.data[4:0];
      IDX_HBLANK:    if (wr.en) nxt_cfg.hblank = wr.data[4:0];
      IDX_FRAME_POS: if (wr.en) nxt_cfg.frame_pos = wr.data[5:0];
      IDX_VBLANK:    if (wr.en) nxt_cfg.vblank = wr.data[5:0];
      default:       nxt_cfg = cfg_ff;
    endcase
  end

  // Register reads; unused bits read zero
  always_comb
  begin
    rd_data = 8'h00;
    rd_ok   = 1'b1;
    unique case (rd_idx)
      IDX_PANEL_CFG: rd_data[AMODE_BIT] = cfg_ff.amode;
      IDX_HSIZE:     rd_data[6:0] = cfg_ff.hsize;
      IDX_VSIZE_LO:  rd_data = cfg_ff.vsize[7:0];
      IDX_VSIZE_HI:  rd_data[1:0] = cfg_ff.vsize[9:8];
      IDX_LINE_POS:  rd_data[4:0] = cfg_ff.line_pos;
      IDX_HBLANK:    rd_data[4:0] = cfg_ff.hblank;
      IDX_FRAME_POS: rd_data[5:0] = cfg_ff.frame_pos;
      IDX_VBLANK:
      begin
        // Status high while past the data lines
        rd_data[5:0]            = cfg_ff.vblank;
        rd_data[VBLANK_STAT_BIT] = !in_vact;
      end
      default:       rd_ok = 1'b0;
    endcase
  end

  // Geometry derived from the registers
  assign w_pix       = {({1'b0, cfg_ff.hsize} + 8'h01), 3'b000};
  assign hblank_pix  = {2'b00, ({1'b0, cfg_ff.hblank} + HBLANK_ADD), 3'b000};
  assign line_total  = w_pix + hblank_pix;
  assign lpos_pix    = {2'b00, ({1'b0, cfg_ff.line_pos} + LINE_POS_ADD), 3'b000};
  assign lsync_start = cfg_ff.amode ? (w_pix + lpos_pix) : w_pix;
  assign v_lines     = {1'b0, cfg_ff.vsize} + 11'h001;
  assign frame_total = v_lines + {5'h00, cfg_ff.vblank};
  // Active: frame sync leads the chosen number of lines after the last data line
  assign fsync_line  = !cfg_ff.amode ? ((cfg_ff.vblank == 6'h00) ? 11'h000 : v_lines) :
                       (v_lines + {5'h00, cfg_ff.frame_pos} - 11'h001);

  assign in_hact     = hcnt_ff < w_pix;
  assign in_vact     = vcnt_ff < v_lines;
  assign in_act      = in_hact && in_vact;
  assign line_end    = hcnt_ff >= (line_total - 11'h001);
  assign frame_end   = vcnt_ff >= (frame_total - 11'h001);

  assign pixel_ready        = in_act;
  assign panel_pixel_data   = pix_ff;
  assign line_sync_pulse    = lsync_ff;
  assign frame_sync_pulse   = fsync_ff;
  assign active_matrix_mode = cfg_ff.amode;

  // Pixel and line counters plus registered panel outputs
  // Wrap tests use >= so a shrunk geometry recovers within a line
  always_comb
  begin
    nxt_hcnt  = hcnt_ff + 11'h001;
    nxt_vcnt  = vcnt_ff;
    if (line_end)
    begin
      nxt_hcnt = 11'h000;
      nxt_vcnt = frame_end ? 11'h000 : (vcnt_ff + 11'h001);
    end
    nxt_pix   = in_act ? pixel_in : 8'h00;
    nxt_lsync = (hcnt_ff >= lsync_start) && (hcnt_ff < (lsync_start + LSYNC_PIX));
    nxt_fsync = (vcnt_ff == fsync_line);
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_ff <= '{amode: RST_AMODE, hsize: RST_HSIZE, vsize: RST_VSIZE,
                  line_pos: RST_LINE_POS, hblank: RST_HBLANK,
                  frame_pos: RST_FRAME_POS, vblank: RST_VBLANK};
    else
      cfg_ff <= nxt_cfg;
  end

  // Counters and panel outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hcnt_ff  <= 11'h000;
      vcnt_ff  <= 11'h000;
      pix_ff   <= 8'h00;
      lsync_ff <= 1'b0;
      fsync_ff <= 1'b0;
    end
    else
    begin
      hcnt_ff  <= nxt_hcnt;
      vcnt_ff  <= nxt_vcnt;
      pix_ff   <= nxt_pix;
      lsync_ff <= nxt_lsync;
      fsync_ff <= nxt_fsync;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_hact_edge: assert property (
    (hcnt_ff == w_pix - 11'h001 && in_vact) |-> in_act ##1 (!in_act || $changed(cfg_ff)))
    else $error("active width not hsize+1 groups of 8");

  chk_vact_edge: assert property (
    (vcnt_ff == v_lines && hcnt_ff == 11'h000) |-> !in_vact && !pixel_ready)
    else $error("active height not vsize+1");

  chk_vsize_max: assert property (
    v_lines <= 11'h400 && v_lines >= 11'h001)
    else $error("vertical line count out of range");

  chk_lsync_place: assert property (
    (cfg_ff.amode && hcnt_ff == w_pix + lpos_pix && $stable(cfg_ff))
    |=> line_sync_pulse ##[1:8] !line_sync_pulse)
    else $error("active line sync misplaced");

  chk_lsync_passive: assert property (
    (!cfg_ff.amode && hcnt_ff == w_pix && $stable(cfg_ff)) |=> $rose(line_sync_pulse))
    else $error("passive line sync ignores mode");

  chk_mode_out: assert property (
    (wr.en && wr.idx == IDX_PANEL_CFG) |=> active_matrix_mode == $past(wr.data[AMODE_BIT]))
    else $error("panel type bit not applied");

  chk_line_len: assert property (
    (line_end && $stable(cfg_ff)) |=> hcnt_ff == 11'h000)
    else $error("line period not width plus blank");

  chk_fsync_place: assert property (
    (cfg_ff.amode && vcnt_ff == v_lines + {5'h00, cfg_ff.frame_pos} - 11'h001)
    |=> frame_sync_pulse)
    else $error("active frame sync misplaced");

  chk_frame_len: assert property (
    (line_end && frame_end && $stable(cfg_ff)) |=> vcnt_ff == 11'h000 ##1 vcnt_ff == 11'h000)
    else $error("frame period not lines plus blank");

  chk_data_quiet: assert property (
    !in_act |=> panel_pixel_data == 8'h00)
    else $error("pixel data driven outside active region");

  chk_data_follow: assert property (
    in_act |=> panel_pixel_data == $past(pixel_in))
    else $error("active pixel not passed through");

  chk_fsync_passive: assert property (
    (!cfg_ff.amode && cfg_ff.vblank != 6'h00 && frame_sync_pulse && $stable(cfg_ff))
    |-> $past(vcnt_ff) == v_lines)
    else $error("passive frame sync moved by position");

  chk_vblank_stat: assert property (
    (rd_idx == IDX_VBLANK && vcnt_ff >= v_lines) |-> rd_data[VBLANK_STAT_BIT])
    else $error("vertical blank status low in blank");

  chk_mode_hold: assert property (
    !(wr.en && wr.idx == IDX_PANEL_CFG) |=> $stable(active_matrix_mode))
    else $error("panel type changed without a write");

  chk_hblank_end: assert property (
    (line_end && !$past(line_end) && $stable(cfg_ff)) |-> hcnt_ff == line_total - 11'h001)
    else $error("horizontal blank length wrong");

  cov_line_wrap:   cover property (line_end ##1 hcnt_ff == 11'h000);
  cov_frame_wrap:  cover property (frame_end && line_end ##1 vcnt_ff == 11'h000);
  cov_amode_fsync: cover property (cfg_ff.amode && $rose(frame_sync_pulse));
  cov_reg_write:   cover property (wr.en && wr.idx == IDX_HSIZE);
  cov_pasv_fsync:  cover property (!cfg_ff.amode && $rose(frame_sync_pulse));

endmodule
